/* core/accel_fifo_pkg.sv */
// constants, field layouts and carrier types for the sample buffer
// assumes a byte-wide register port behind the serial interface
package accel_fifo_pkg;
  localparam int SAMPLE_WIDTH = 14;
  localparam int BUFFER_DEPTH = 32;
  localparam int COUNT_WIDTH = 6;
  localparam int THRESHOLD_WIDTH = 5;
  // register offsets
  localparam logic [6:0] ADDR_INTERFACE_CONTROL = 7'h21;
  localparam logic [6:0] ADDR_PIN_ONE_ROUTING = 7'h23;
  localparam logic [6:0] ADDR_PIN_TWO_ROUTING = 7'h24;
  localparam logic [6:0] ADDR_OUT_FIRST = 7'h28;
  localparam logic [6:0] ADDR_OUT_LAST = 7'h2D;
  localparam logic [6:0] ADDR_FIFO_CONTROL = 7'h2E;
  localparam logic [6:0] ADDR_FIFO_STATUS = 7'h2F;
  // reset values
  localparam logic [7:0] RESET_INTERFACE_CONTROL = 8'h04;
  localparam logic [7:0] RESET_ROUTING = 8'h00;
  localparam logic [7:0] RESET_FIFO_CONTROL = 8'h00;
  // field positions
  localparam int AUTO_INCREMENT_BIT = 2;
  localparam int THRESHOLD_ROUTE_BIT = 1;
  localparam int WAKE_ROUTE_BIT = 5;
  localparam int FREEFALL_ROUTE_BIT = 4;
  localparam int ORIENT_ROUTE_BIT = 7;
  localparam int MODE_LSB = 5;
  localparam int STATUS_THRESHOLD_BIT = 7;
  localparam int STATUS_OVERRUN_BIT = 6;
  localparam int FRACTION_BITS = 6;
  // buffer_mode_select codes
  localparam logic [2:0] MODE_BYPASS = 3'h0;
  localparam logic [2:0] MODE_STOP_FULL = 3'h1;
  localparam logic [2:0] MODE_CONT_TO_STOP = 3'h3;
  localparam logic [2:0] MODE_BYPASS_TO_CONT = 3'h4;
  localparam logic [2:0] MODE_CONTINUOUS = 3'h6;

  typedef enum logic [2:0] {
    BEH_BYPASS = 3'b001,
    BEH_STOP = 3'b010,
    BEH_CONT = 3'b100
  } behaviour_type;

  typedef struct packed {
    logic [SAMPLE_WIDTH-1:0] x;
    logic [SAMPLE_WIDTH-1:0] y;
    logic [SAMPLE_WIDTH-1:0] z;
  } sample_set_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic new_addr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic wake;
    logic freefall;
    logic orient;
  } event_set_type;
endpackage

/* core/accel_sample_fifo.sv */
// sample buffer with modes, fill count, flags and output read window
// assumes one byte access per request from the serial interface
//
// Overview of operation
// - hold 32 sets of three 14-bit values
// - buffered modes read oldest set at 28h-2Dh
// - auto-increment each byte, 2Dh wraps to 28h
// - threshold flag when count reaches threshold
// - zero threshold keeps threshold flag cleared
// - overrun flag on overwriting an unread slot
// - six-bit unread count, 32 means full
// - bypass stores nothing, shows newest sample
// - writing bypass empties buffer; 001 restarts
// - stop-when-full mode halts at 32 sets
// - continuous mode overwrites oldest, raises overrun
// - threshold flag routed to pins one, two
// - mode 011: continuous until trigger, then stop
// - trigger is wake, free-fall or 6D routed to pin one
// - mode 100: bypass until trigger, then continuous
`timescale 1ns/10ps
module accel_sample_fifo #(
  parameter int DEPTH = accel_fifo_pkg::BUFFER_DEPTH
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  // sample stream
  input wire logic i_sample_valid,
  input wire accel_fifo_pkg::sample_set_type i_sample,
  // detector events
  input wire accel_fifo_pkg::event_set_type i_events,
  // register port
  input wire accel_fifo_pkg::reg_req_type i_reg,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // interrupt pins
  output logic o_interrupt_pin_one,
  output logic o_interrupt_pin_two
);
  import accel_fifo_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [COUNT_WIDTH-1:0] FULL_COUNT = COUNT_WIDTH'(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] interface_control;
  logic [7:0] pin_one_routing;
  logic [7:0] pin_two_routing;
  logic [7:0] fifo_control;
  logic [6:0] cur_addr;
  logic [7:0] next_interface_control;
  logic [7:0] next_pin_one_routing;
  logic [7:0] next_pin_two_routing;
  logic [7:0] next_fifo_control;
  logic [6:0] next_cur_addr;
  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;

  // buffer state
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [COUNT_WIDTH-1:0] count;
  logic overrun_flag;
  logic triggered;
  sample_set_type newest;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [COUNT_WIDTH-1:0] next_count;
  logic next_overrun_flag;
  logic next_triggered;
  sample_set_type next_newest;

  // decode
  logic [6:0] acc_addr;
  logic access;
  logic mode_write;
  logic [2:0] buffer_mode_select;
  logic [THRESHOLD_WIDTH-1:0] fill_threshold;
  behaviour_type behaviour;
  logic trigger_hit;
  logic push;
  logic pop_req;
  logic do_pop;
  logic room;
  logic store;
  logic overwrite;
  logic clear_buffer;
  logic threshold_flag;
  sample_set_type head;
  sample_set_type shown;

  assign buffer_mode_select = fifo_control[MODE_LSB +: 3];
  assign fill_threshold = fifo_control[THRESHOLD_WIDTH-1:0];
  assign acc_addr = i_reg.new_addr ? i_reg.addr : cur_addr;
  assign access = i_reg.rd | i_reg.wr;
  assign mode_write = i_reg.wr && (acc_addr == ADDR_FIFO_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // mode behaviour and trigger
  always_comb begin
    trigger_hit = (i_events.wake & pin_one_routing[WAKE_ROUTE_BIT])
      | (i_events.freefall & pin_one_routing[FREEFALL_ROUTE_BIT])
      | (i_events.orient & pin_one_routing[ORIENT_ROUTE_BIT]);
    case (buffer_mode_select)
      MODE_STOP_FULL: behaviour = BEH_STOP;
      MODE_CONTINUOUS: behaviour = BEH_CONT;
      MODE_CONT_TO_STOP: behaviour = triggered ? BEH_STOP : BEH_CONT;
      MODE_BYPASS_TO_CONT: behaviour = triggered ? BEH_CONT : BEH_BYPASS;
      default: behaviour = BEH_BYPASS;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer next state
  always_comb begin
    push = i_sample_valid && (behaviour != BEH_BYPASS);
    pop_req = i_reg.rd && (acc_addr == ADDR_OUT_LAST) && (behaviour != BEH_BYPASS);
    do_pop = pop_req && (count != '0);
    room = (count < FULL_COUNT) || do_pop;
    store = push && (room || behaviour == BEH_CONT);
    overwrite = push && !room && (behaviour == BEH_CONT);
    clear_buffer = (behaviour == BEH_BYPASS) || (mode_write && !(i_reg.wdata[MODE_LSB +: 3]
      inside {MODE_STOP_FULL, MODE_CONTINUOUS, MODE_CONT_TO_STOP}));
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_overrun_flag = overrun_flag;
    next_triggered = triggered;
    next_newest = newest;
    if (i_sample_valid) begin
      next_newest = i_sample;
    end
    if (clear_buffer) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
      next_overrun_flag = 1'b0;
    end else begin
      if (store) begin
        next_wr_ptr = PTR_W'(wr_ptr + 1'b1);
      end
      if (do_pop || overwrite) begin
        next_rd_ptr = PTR_W'(rd_ptr + 1'b1);
      end
      if (store && room && !do_pop) begin
        next_count = COUNT_WIDTH'(count + 1'b1);
      end else if (do_pop && !store) begin
        next_count = COUNT_WIDTH'(count - 1'b1);
      end
      // a new overwrite outranks the clear that draining brings
      if (overwrite) begin
        next_overrun_flag = 1'b1;
      end else if (do_pop) begin
        next_overrun_flag = 1'b0;
      end
    end
    if (mode_write) begin
      next_triggered = 1'b0;
    end else if (trigger_hit && (buffer_mode_select == MODE_CONT_TO_STOP
      || buffer_mode_select == MODE_BYPASS_TO_CONT)) begin
      next_triggered = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      overrun_flag <= 1'b0;
      triggered <= 1'b0;
      newest <= '0;
    end else if (i_clk_en) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      overrun_flag <= next_overrun_flag;
      triggered <= next_triggered;
      newest <= next_newest;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage and flags
  sample_store #(
    .DEPTH(DEPTH),
    .PTR_WIDTH(PTR_W)
  ) u_store (
    .i_sys_clk(i_sys_clk),
    .i_clk_en(i_clk_en),
    .i_wr_en(store && !clear_buffer),
    .i_wr_ptr(wr_ptr),
    .i_wr_data(i_sample),
    .i_rd_ptr(rd_ptr),
    .o_rd_data(head)
  );

  fill_flags #(
    .COUNT_W(COUNT_WIDTH),
    .FTH_W(THRESHOLD_WIDTH)
  ) u_flags (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_clk_en(i_clk_en),
    .i_count(count),
    .i_fill_threshold(fill_threshold),
    .i_pin_one_threshold_route(pin_one_routing[THRESHOLD_ROUTE_BIT]),
    .i_pin_two_threshold_route(pin_two_routing[THRESHOLD_ROUTE_BIT]),
    .o_threshold_flag(threshold_flag),
    .o_interrupt_pin_one(o_interrupt_pin_one),
    .o_interrupt_pin_two(o_interrupt_pin_two)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port
  function automatic logic [7:0] out_byte(input sample_set_type s, input logic [2:0] idx);
    logic [SAMPLE_WIDTH-1:0] v;
    v = (idx[2:1] == 2'd0) ? s.x : (idx[2:1] == 2'd1) ? s.y : s.z;
    if (idx[0]) begin
      out_byte = v[SAMPLE_WIDTH-1:FRACTION_BITS];
    end else begin
      out_byte = {v[FRACTION_BITS-1:0], 2'b00};
    end
  endfunction

  always_comb begin
    shown = (behaviour == BEH_BYPASS) ? newest : head;
    next_interface_control = interface_control;
    next_pin_one_routing = pin_one_routing;
    next_pin_two_routing = pin_two_routing;
    next_fifo_control = fifo_control;
    next_cur_addr = cur_addr;
    next_reg_rdata = o_reg_rdata;
    next_reg_rvalid = i_reg.rd;
    if (i_reg.wr) begin
      case (acc_addr)
        ADDR_INTERFACE_CONTROL: next_interface_control = i_reg.wdata;
        ADDR_PIN_ONE_ROUTING: next_pin_one_routing = i_reg.wdata;
        ADDR_PIN_TWO_ROUTING: next_pin_two_routing = i_reg.wdata;
        ADDR_FIFO_CONTROL: next_fifo_control = i_reg.wdata;
        default: next_fifo_control = fifo_control;
      endcase
    end
    if (i_reg.rd) begin
      if (acc_addr >= ADDR_OUT_FIRST && acc_addr <= ADDR_OUT_LAST) begin
        next_reg_rdata = out_byte(shown, 3'(acc_addr - ADDR_OUT_FIRST));
      end else begin
        case (acc_addr)
          ADDR_INTERFACE_CONTROL: next_reg_rdata = interface_control;
          ADDR_PIN_ONE_ROUTING: next_reg_rdata = pin_one_routing;
          ADDR_PIN_TWO_ROUTING: next_reg_rdata = pin_two_routing;
          ADDR_FIFO_CONTROL: next_reg_rdata = fifo_control;
          ADDR_FIFO_STATUS: next_reg_rdata = {threshold_flag, overrun_flag, count};
          default: next_reg_rdata = 8'h00;
        endcase
      end
    end
    if (access) begin
      next_cur_addr = acc_addr;
      if (interface_control[AUTO_INCREMENT_BIT]) begin
        if (acc_addr == ADDR_OUT_LAST) begin
          next_cur_addr = ADDR_OUT_FIRST;
        end else begin
          next_cur_addr = 7'(acc_addr + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      interface_control <= RESET_INTERFACE_CONTROL;
      pin_one_routing <= RESET_ROUTING;
      pin_two_routing <= RESET_ROUTING;
      fifo_control <= RESET_FIFO_CONTROL;
      cur_addr <= '0;
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else if (i_clk_en) begin
      interface_control <= next_interface_control;
      pin_one_routing <= next_pin_one_routing;
      pin_two_routing <= next_pin_two_routing;
      fifo_control <= next_fifo_control;
      cur_addr <= next_cur_addr;
      o_reg_rdata <= next_reg_rdata;
      o_reg_rvalid <= next_reg_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_COUNT_BOUND: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    count <= FULL_COUNT)
    else $error("unread count above depth");

  AST_BYPASS_EMPTY: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_clk_en && behaviour == BEH_BYPASS) |=> (count == '0))
    else $error("bypass left data in buffer");

  AST_STOP_HOLDS_FULL: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_clk_en && behaviour == BEH_STOP && count == FULL_COUNT && !do_pop && !mode_write)
    |=> (count == FULL_COUNT) && $stable(wr_ptr))
    else $error("stop mode stored past full");

  AST_OVERWRITE_OVERRUN: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_clk_en && behaviour == BEH_CONT && count == FULL_COUNT && i_sample_valid
      && !do_pop && !mode_write)
    |=> overrun_flag && (count == FULL_COUNT) && (rd_ptr == PTR_W'($past(rd_ptr) + 1'b1)))
    else $error("continuous overwrite without overrun");

  AST_OVERRUN_CAUSE: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(overrun_flag) |-> $past(overwrite))
    else $error("overrun raised without overwrite");

  AST_POP_DECREMENTS: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_clk_en && do_pop && !push && !clear_buffer) |=> (count == $past(count) - 1'b1))
    else $error("final byte read did not pop");

  AST_WRAP_ADDRESS: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_clk_en && access && acc_addr == ADDR_OUT_LAST && interface_control[AUTO_INCREMENT_BIT])
    |=> (cur_addr == ADDR_OUT_FIRST))
    else $error("read window did not wrap");

  AST_BYPASS_WRITE_CLEARS: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_clk_en && mode_write && i_reg.wdata[MODE_LSB +: 3] == MODE_BYPASS)
    |=> (count == '0) && !overrun_flag)
    else $error("bypass write did not clear buffer");

  AST_TRIGGER_START: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_clk_en && buffer_mode_select == MODE_BYPASS_TO_CONT && !triggered && !mode_write)
    |-> (count == '0) && !store)
    else $error("bypass-to-continuous stored before trigger");

  AST_THRESHOLD_TRACK: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_clk_en && fill_threshold != '0 && count >= {1'b0, fill_threshold})
    |=> threshold_flag)
    else $error("threshold flag missing at threshold");
endmodule

/* core/fill_flags.sv */
// threshold flag and interrupt pin drive
// assumes count and threshold come from the same clock domain
`timescale 1ns/10ps
module fill_flags #(
  parameter int COUNT_W = 6,
  parameter int FTH_W = 5
) (
  // clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  // fill state and pin routing
  input wire logic [COUNT_W-1:0] i_count,
  input wire logic [FTH_W-1:0] i_fill_threshold,
  input wire logic i_pin_one_threshold_route,
  input wire logic i_pin_two_threshold_route,
  // flags
  output logic o_threshold_flag,
  output logic o_interrupt_pin_one,
  output logic o_interrupt_pin_two
);
  logic next_threshold_flag;
  logic next_pin_one;
  logic next_pin_two;

  always_comb begin
    next_threshold_flag = 1'b0;
    if (i_fill_threshold != '0) begin
      next_threshold_flag = (i_count >= {1'b0, i_fill_threshold});
    end
    next_pin_one = next_threshold_flag & i_pin_one_threshold_route;
    next_pin_two = next_threshold_flag & i_pin_two_threshold_route;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_threshold_flag <= 1'b0;
      o_interrupt_pin_one <= 1'b0;
      o_interrupt_pin_two <= 1'b0;
    end else if (i_clk_en) begin
      o_threshold_flag <= next_threshold_flag;
      o_interrupt_pin_one <= next_pin_one;
      o_interrupt_pin_two <= next_pin_two;
    end
  end

  AST_ZERO_THRESHOLD_CLEAR: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_clk_en && i_fill_threshold == '0) |=> !o_threshold_flag)
    else $error("threshold flag set with zero threshold");
endmodule

/* core/sample_store.sv */
// storage array of sample sets, one write port, one read port
// assumes the caller keeps pointers in range
`timescale 1ns/10ps
module sample_store #(
  parameter int DEPTH = 32,
  parameter int PTR_WIDTH = 5
) (
  // clock and enable
  input wire logic i_sys_clk,
  input wire logic i_clk_en,
  // write side
  input wire logic i_wr_en,
  input wire logic [PTR_WIDTH-1:0] i_wr_ptr,
  input wire accel_fifo_pkg::sample_set_type i_wr_data,
  // read side
  input wire logic [PTR_WIDTH-1:0] i_rd_ptr,
  output accel_fifo_pkg::sample_set_type o_rd_data
);
  import accel_fifo_pkg::*;

  sample_set_type mem [DEPTH];

  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && i_wr_en) begin
      mem[i_wr_ptr] <= i_wr_data;
    end
  end

  assign o_rd_data = mem[i_rd_ptr];
endmodule

/* dv/accel_host_model.sv */
// host model: byte reads and writes on the block's register port
// assumes the block takes requests on the rising edge, answers one cycle later
`timescale 1ns/10ps
module accel_host_model (
  // clock
  input wire logic i_sys_clk,
  // register port
  output accel_fifo_pkg::reg_req_type o_reg,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid
);
  import accel_fifo_pkg::*;
  initial o_reg = '0;
  ////////////////////////////////////////////////////////////////////////////
  // one byte write, held for one taking edge
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    @(negedge i_sys_clk);
    o_reg = '{rd: 1'b0, wr: 1'b1, new_addr: 1'b1, addr: addr, wdata: data};
    @(negedge i_sys_clk);
    o_reg = '{rd: 1'b0, wr: 1'b0, new_addr: 1'b0, addr: ~addr, wdata: ~data};
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // one byte read, answer taken in the cycle it stands
  task automatic read_reg(input logic [6:0] addr, input logic new_addr,
                          output logic [7:0] data, output logic valid);
    @(negedge i_sys_clk);
    o_reg = '{rd: 1'b1, wr: 1'b0, new_addr: new_addr, addr: addr, wdata: 8'h00};
    @(negedge i_sys_clk);
    data = i_reg_rdata;
    valid = i_reg_rvalid;
    o_reg = '{rd: 1'b0, wr: 1'b0, new_addr: 1'b0, addr: ~addr, wdata: 8'hff};
  endtask
endmodule

/* dv/accel_sample_fifo_bench.sv */
// self-checking bench for the sample buffer
// assumes the host model drives the register port, bench drives samples
`timescale 1ns/10ps
module accel_sample_fifo_bench;
  import accel_fifo_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_clk_en = 1'b1;
  logic i_sample_valid = 1'b0;
  sample_set_type i_sample = '0;
  event_set_type i_events = '0;
  reg_req_type host_req;
  logic [7:0] o_reg_rdata, junk;
  logic o_reg_rvalid, pin_one, pin_two, junk_v;
  int miscompares = 0;
  int n_tests = 0;
  int sample_seq = 0;
  int base = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  accel_sample_fifo i_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en),
    .i_sample_valid(i_sample_valid), .i_sample(i_sample), .i_events(i_events),
    .i_reg(host_req), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_interrupt_pin_one(pin_one), .o_interrupt_pin_two(pin_two));
  accel_host_model i_host (.i_sys_clk(i_sys_clk), .o_reg(host_req),
    .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid));
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic sample_set_type smp(input int i);
    return '{x: 14'h1000 + i[13:0], y: 14'h2a00 + i[13:0], z: 14'h0300 + i[13:0]};
  endfunction
  function automatic logic [7:0] byte_of(input sample_set_type s, input int k);
    logic [13:0] v;
    v = (k < 2) ? s.x : (k < 4) ? s.y : s.z;
    return k[0] ? v[13:6] : {v[5:0], 2'b00};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [6:0] addr, input logic na, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    i_host.read_reg(addr, na, d, v);
    check({7'h00, v}, 8'h01, "read answer");
    check(d, exp, "read byte");
  endtask
  task automatic read_set_chk(input int idx);
    for (int k = 0; k < 6; k++) begin
      rd_chk(ADDR_OUT_FIRST + 7'(k), k == 0, byte_of(smp(idx), k));
    end
  endtask
  task automatic push(input int n);
    repeat (n) begin
      @(negedge i_sys_clk);
      i_sample_valid = 1'b1;
      i_sample = smp(sample_seq);
      sample_seq++;
      @(negedge i_sys_clk);
      i_sample_valid = 1'b0;
      i_sample = ~i_sample;
    end
    repeat (3) @(negedge i_sys_clk);
  endtask
  task automatic pulse(input event_set_type e);
    @(negedge i_sys_clk);
    i_events = e;
    @(negedge i_sys_clk);
    i_events = '0;
  endtask
  task automatic set_mode(input logic [2:0] m, input logic [4:0] thr);
    i_host.write_reg(ADDR_FIFO_CONTROL, {m, thr});
  endtask
  task automatic pins_chk(input logic one, input logic two);
    repeat (2) @(negedge i_sys_clk);
    check({7'h00, pin_one}, {7'h00, one}, "pin one");
    check({7'h00, pin_two}, {7'h00, two}, "pin two");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    repeat (5) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    rd_chk(ADDR_INTERFACE_CONTROL, 1'b1, 8'h04);
    rd_chk(ADDR_PIN_ONE_ROUTING, 1'b1, 8'h00);
    rd_chk(ADDR_PIN_TWO_ROUTING, 1'b1, 8'h00);
    rd_chk(ADDR_FIFO_CONTROL, 1'b1, 8'h00);
    i_host.write_reg(ADDR_FIFO_STATUS, 8'hff);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h00);
    rd_chk(7'h30, 1'b1, 8'h00);
    $display("test reset values done");
    push(2);
    read_set_chk(1);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h00);
    $display("test bypass done");
    i_host.write_reg(ADDR_PIN_ONE_ROUTING, 8'h02);
    set_mode(MODE_STOP_FULL, 5'h05);
    base = sample_seq;
    push(4);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h04);
    pins_chk(1'b0, 1'b0);
    push(1);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h85);
    push(28);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'ha0);
    pins_chk(1'b1, 1'b0);
    i_host.write_reg(ADDR_PIN_TWO_ROUTING, 8'h02);
    pins_chk(1'b1, 1'b1);
    read_set_chk(base);
    rd_chk(ADDR_OUT_FIRST, 1'b0, byte_of(smp(base + 1), 0));
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h9f);
    $display("test stop when full done");
    set_mode(MODE_BYPASS, 5'h05);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h00);
    set_mode(MODE_STOP_FULL, 5'h00);
    push(3);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h03);
    pins_chk(1'b0, 1'b0);
    i_clk_en = 1'b0;
    push(1);
    i_clk_en = 1'b1;
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h03);
    $display("test clear and zero threshold done");
    set_mode(MODE_BYPASS, 5'h00);
    set_mode(MODE_CONTINUOUS, 5'h00);
    base = sample_seq;
    push(34);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h60);
    read_set_chk(base + 2);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h1f);
    $display("test continuous done");
    set_mode(MODE_BYPASS, 5'h00);
    set_mode(MODE_BYPASS_TO_CONT, 5'h00);
    pulse('{wake: 1'b0, freefall: 1'b1, orient: 1'b0});
    push(2);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h00);
    i_host.write_reg(ADDR_PIN_ONE_ROUTING, 8'h22);
    pulse('{wake: 1'b1, freefall: 1'b0, orient: 1'b0});
    base = sample_seq;
    push(3);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h03);
    for (int k = 0; k < 6; k++) begin
      i_host.read_reg(ADDR_OUT_FIRST + 7'(k), k == 0, junk, junk_v);
    end
    read_set_chk(base + 1);
    $display("test bypass to continuous done");
    set_mode(MODE_BYPASS, 5'h00);
    i_host.write_reg(ADDR_PIN_ONE_ROUTING, 8'h82);
    set_mode(MODE_CONT_TO_STOP, 5'h00);
    base = sample_seq;
    push(40);
    pulse('{wake: 1'b0, freefall: 1'b0, orient: 1'b1});
    push(3);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h60);
    read_set_chk(base + 8);
    $display("test continuous to stop done");
    set_mode(3'h7, 5'h00);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h00);
    push(1);
    rd_chk(ADDR_FIFO_STATUS, 1'b1, 8'h00);
    read_set_chk(sample_seq - 1);
    $display("test unknown mode done");
    tally_and_finish();
  end
endmodule
